// ==== core/xldc_core.sv ====
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module xldc_core #(
   parameter int FIFO_DEPTH = 8,
   parameter int COMP_LO = 2,
   parameter int COMP_HI = 6
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // configuration terminals
   input wire logic mode_select_lo,
   input wire logic mode_select_hi,
   input wire logic selftest_enable_pin,
   input wire logic sync_enable_input,
   // transmit
   input wire xldc_pkg::xldc_tx_in_type tx_in,
   output var xldc_pkg::xldc_ser_out_type serial_tx,
   output logic [xldc_pkg::LANES-1:0][1:0] lane_preemph,
   // receive
   input wire logic [xldc_pkg::LANES-1:0] serial_rx_pair,
   input wire logic [xldc_pkg::LANES-1:0] serial_rx_strobe,
   output logic [xldc_pkg::LANES-1:0][xldc_pkg::WORD_W-1:0] rx_code,
   output logic [xldc_pkg::LANES-1:0] rx_code_valid,
   input wire xldc_pkg::xldc_dec_in_type dec_in,
   output var xldc_pkg::xldc_rx_out_type rx_out,
   output logic lane_a_rx_clock,
   output logic [xldc_pkg::LANES-1:0] lane_multifunction_out,
   // power
   output logic tx_power_en,
   output logic rx_power_en
);
   import xldc_pkg::*;

   localparam int PW = $clog2(FIFO_DEPTH);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] LO_C = CW'(COMP_LO);
   localparam logic [CW-1:0] HI_C = CW'(COMP_HI);
   localparam logic [CW-1:0] FULL_C = CW'(FIFO_DEPTH);
   localparam logic [CW-1:0] TWO_C = CW'(2);
   localparam logic [PW-1:0] ONE_P = PW'(1);
   localparam logic [8:0] IDLE_ENT = {1'b1, IDLE_BYTE};

   if (FIFO_DEPTH < 4 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || COMP_LO < 1 ||
       COMP_HI <= COMP_LO || COMP_HI >= FIFO_DEPTH) begin : g_bad
      $error("xldc_core: FIFO_DEPTH must be a power of two with 1 <= LO < HI < DEPTH");
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic prbs_bit(input logic [6:0] h);
      return h[6] ^ h[5];
   endfunction : prbs_bit

   function automatic logic [16:0] prbs7_word(input logic [6:0] s);
      logic [6:0] st;
      logic [9:0] w;
      st = s;
      w = '0;
      for (int i = 0; i < WORD_W; i++) begin
         w[i] = prbs_bit(st);
         st = {st[5:0], w[i]};
      end
      return {st, w};
   endfunction : prbs7_word

   function automatic logic is_idle(input logic [8:0] e);
      return e[8] && (e[7:0] == CHAR_A || e[7:0] == CHAR_K || e[7:0] == CHAR_R);
   endfunction : is_idle

   function automatic logic [8:0] to_xgmii(input logic [8:0] e);
      return is_idle(e) ? IDLE_ENT : e;
   endfunction : to_xgmii

   function automatic logic [2:0] lane_hit(input logic [7:0] i);
      return {(i >= IDX_LANE_A && i <= IDX_LANE_D), 2'(i - IDX_LANE_A)};
   endfunction : lane_hit

   // ------------------------------------------------------------
   // apb register file
   // ------------------------------------------------------------
   logic [GLOBAL_W-1:0] glob_reg;
   logic [LANES-1:0][LANE_W-1:0] lane_reg;
   logic [LANES-1:0] pass_reg;
   xldc_mode_type eff_mode_reg;
   logic [7:0] idx;
   logic [2:0] lh;
   logic access, mapped, commit;
   logic [31:0] rd_data;

   assign idx = paddr[9:2];
   assign lh = lane_hit(idx);
   assign access = psel && penable;
   assign commit = access && pready;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                   (idx == IDX_GLOBAL || lh[2] || idx == IDX_STATUS);

   always_comb begin
      rd_data = '0;
      if (idx == IDX_GLOBAL) begin
         rd_data[GLOBAL_W-1:0] = glob_reg;
      end else if (lh[2]) begin
         rd_data[LANE_W-1:0] = lane_reg[lh[1:0]];
      end else if (idx == IDX_STATUS) begin
         rd_data[ST_PASS_LSB +: LANES] = pass_reg;
         rd_data[ST_MODE_LSB +: 2] = eff_mode_reg;
      end
   end

   // one wait state: answer in the cycle after the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= access && !pready;
         pslverr <= access && !pready && !mapped;
         if (access && !pready) begin
            prdata <= (mapped && !pwrite) ? rd_data : 32'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         glob_reg <= GLOBAL_RESET;
         lane_reg <= {LANES{LANE_RESET}};
      end else if (commit && pwrite && mapped) begin
         if (idx == IDX_GLOBAL) begin
            glob_reg <= pwdata[GLOBAL_W-1:0];
         end else if (lh[2]) begin
            lane_reg[lh[1:0]] <= pwdata[LANE_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // mode and power
   // ------------------------------------------------------------
   logic tx_act, rx_act, repeat_m, sync_mode, comp_en;
   logic [LANES-1:0] st_en;

   assign tx_act = (eff_mode_reg != MODE_RX_ONLY);
   assign rx_act = (eff_mode_reg != MODE_TX_ONLY);
   assign repeat_m = (eff_mode_reg == MODE_REPEAT);
   assign sync_mode = !glob_reg[GL_IND_MODE];
   assign comp_en = glob_reg[GL_COMP_EN];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_mode_reg <= MODE_DUPLEX;
         tx_power_en <= 1'b0;
         rx_power_en <= 1'b0;
      end else begin
         if (glob_reg[GL_MODE_OVR]) begin
            eff_mode_reg <= xldc_mode_type'(glob_reg[GL_MODE_LSB +: 2]);
         end else begin
            eff_mode_reg <= xldc_mode_type'({mode_select_hi, mode_select_lo});
         end
         tx_power_en <= tx_act;
         rx_power_en <= rx_act;
      end
   end

   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         st_en[l] = selftest_enable_pin || glob_reg[LN_SELFTEST] ||
                    lane_reg[l][LN_SELFTEST];
      end
   end

   // ------------------------------------------------------------
   // transmit: word select and serializer
   // ------------------------------------------------------------
   logic [3:0] tick_cnt_reg;
   logic word_tick;
   logic [LANES-1:0][6:0] prbs_reg, prbs_nxt;
   logic [LANES-1:0][WORD_W-1:0] prbs_bits, tx_word, shreg;
   logic [LANES-1:0] rpt_bit_reg;

   assign word_tick = (tick_cnt_reg == TICK_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 4'h0;
      end else begin
         tick_cnt_reg <= word_tick ? 4'h0 : tick_cnt_reg + 4'h1;
      end
   end

   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         {prbs_nxt[l], prbs_bits[l]} = prbs7_word(prbs_reg[l]);
         if (st_en[l]) begin
            tx_word[l] = prbs_bits[l];
         end else if (!tx_act) begin
            tx_word[l] = '0;
         end else if (lane_reg[l][LN_ENC]) begin
            tx_word[l] = tx_in.enc_word[l];
         end else begin
            tx_word[l] = tx_in.raw_word[l];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prbs_reg <= {LANES{PRBS_SEED}};
         shreg <= '0;
         serial_tx <= '0;
         lane_preemph <= '0;
      end else begin
         for (int l = 0; l < LANES; l++) begin
            if (word_tick && st_en[l]) begin
               prbs_reg[l] <= prbs_nxt[l];
            end
            if (word_tick) begin
               shreg[l] <= tx_word[l];
               serial_tx.data[l] <= repeat_m ? rpt_bit_reg[l] : tx_word[l][0];
            end else begin
               shreg[l] <= {1'b0, shreg[l][WORD_W-1:1]};
               serial_tx.data[l] <= repeat_m ? rpt_bit_reg[l] : shreg[l][1];
            end
            serial_tx.oe[l] <= tx_act;
            lane_preemph[l] <= lane_reg[l][LN_PRE_LSB +: 2];
         end
      end
   end

   // ------------------------------------------------------------
   // receive: deserializer, retiming, self-test checker
   // ------------------------------------------------------------
   logic [LANES-1:0] strobe_g, done_reg, chk_err;
   logic [LANES-1:0][3:0] bit_cnt_reg;
   logic [LANES-1:0][WORD_W-1:0] deser_reg;
   logic [LANES-1:0][6:0] hist_reg;
   logic [LANES-1:0][2:0] lock_reg;

   assign lane_a_rx_clock = done_reg[0];

   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         strobe_g[l] = serial_rx_strobe[l] && rx_act;
         chk_err[l] = (lock_reg[l] == PRBS_LOCK) &&
                      (serial_rx_pair[l] != prbs_bit(hist_reg[l]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_reg <= '0;
         deser_reg <= '0;
         done_reg <= '0;
         rx_code <= '0;
         rx_code_valid <= '0;
         rpt_bit_reg <= '0;
      end else begin
         for (int l = 0; l < LANES; l++) begin
            done_reg[l] <= strobe_g[l] && (bit_cnt_reg[l] == BIT_LAST);
            rx_code_valid[l] <= strobe_g[l] && (bit_cnt_reg[l] == BIT_LAST) &&
                                lane_reg[l][LN_DEC];
            if (strobe_g[l]) begin
               deser_reg[l] <= {serial_rx_pair[l], deser_reg[l][WORD_W-1:1]};
               bit_cnt_reg[l] <= (bit_cnt_reg[l] == BIT_LAST) ? 4'h0 : bit_cnt_reg[l] + 4'h1;
               rpt_bit_reg[l] <= serial_rx_pair[l];
               if (bit_cnt_reg[l] == BIT_LAST) begin
                  rx_code[l] <= {serial_rx_pair[l], deser_reg[l][WORD_W-1:1]};
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist_reg <= '0;
         lock_reg <= '0;
         pass_reg <= '1;
         lane_multifunction_out <= '0;
      end else begin
         for (int l = 0; l < LANES; l++) begin
            if (!st_en[l]) begin
               lock_reg[l] <= 3'h0;
            end else if (strobe_g[l]) begin
               hist_reg[l] <= {hist_reg[l][5:0], serial_rx_pair[l]};
               if (lock_reg[l] != PRBS_LOCK) begin
                  lock_reg[l] <= lock_reg[l] + 3'h1;
               end
               if (sync_enable_input) begin
                  if (chk_err[l]) begin
                     pass_reg[l] <= 1'b0;
                  end
               end else begin
                  pass_reg[l] <= !chk_err[l];
               end
            end
            lane_multifunction_out[l] <= (glob_reg[GL_FLAG_SEL_LSB +: 2] == FLAG_SEL_PASS) &&
                                         pass_reg[l];
         end
      end
   end

   // ------------------------------------------------------------
   // lane FIFOs with clock tolerance compensation
   // ------------------------------------------------------------
   logic [LANES-1:0][FIFO_DEPTH-1:0][8:0] mem;
   logic [LANES-1:0][PW-1:0] wp_reg, rp_reg;
   logic [LANES-1:0][CW-1:0] cnt_reg;
   logic [LANES-1:0][8:0] head, head2;
   logic [LANES-1:0] wr_en, h_r, h_idle, nonempty, ge2, hi, lo;
   logic col_tick;
   logic [1:0] rd_amt;

   assign col_tick = done_reg[0] && sync_mode;

   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         wr_en[l] = done_reg[l] && sync_mode && (cnt_reg[l] != FULL_C);
         head[l] = mem[l][rp_reg[l]];
         head2[l] = mem[l][rp_reg[l] + ONE_P];
         h_r[l] = (head[l] == {1'b1, CHAR_R});
         h_idle[l] = is_idle(head[l]);
         nonempty[l] = (cnt_reg[l] != '0);
         ge2[l] = (cnt_reg[l] >= TWO_C);
         hi[l] = (cnt_reg[l] > HI_C);
         lo[l] = (cnt_reg[l] < LO_C);
      end
   end

   always_comb begin
      rd_amt = 2'h0;
      if (col_tick && (&nonempty)) begin
         if (comp_en && (&h_r) && (&hi) && (&ge2)) begin
            rd_amt = 2'h2;
         end else if (comp_en && (&h_idle) && (|lo)) begin
            rd_amt = 2'h0;
         end else begin
            rd_amt = 2'h1;
         end
      end
   end

   always_ff @(posedge pclk) begin
      for (int l = 0; l < LANES; l++) begin
         if (wr_en[l]) begin
            mem[l][wp_reg[l]] <= {dec_in.ctrl[l], dec_in.data[l]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else if (!sync_mode) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         for (int l = 0; l < LANES; l++) begin
            if (wr_en[l]) begin
               wp_reg[l] <= wp_reg[l] + ONE_P;
            end
            rp_reg[l] <= rp_reg[l] + PW'(rd_amt);
            cnt_reg[l] <= cnt_reg[l] + CW'(wr_en[l]) - CW'(rd_amt);
         end
      end
   end

   // ------------------------------------------------------------
   // parallel receive bus
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_out <= '0;
      end else begin
         rx_out.oe <= rx_act;
         for (int l = 0; l < LANES; l++) begin
            if (!sync_mode) begin
               rx_out.valid[l] <= done_reg[l];
               if (done_reg[l]) begin
                  {rx_out.ctrl[l], rx_out.data[l]} <=
                     to_xgmii({dec_in.ctrl[l], dec_in.data[l]});
               end
            end else begin
               rx_out.valid[l] <= col_tick;
               if (col_tick) begin
                  if (rd_amt == 2'h2) begin
                     {rx_out.ctrl[l], rx_out.data[l]} <= to_xgmii(head2[l]);
                  end else if (rd_amt == 2'h1) begin
                     {rx_out.ctrl[l], rx_out.data[l]} <= to_xgmii(head[l]);
                  end else begin
                     {rx_out.ctrl[l], rx_out.data[l]} <= IDLE_ENT;
                  end
               end
            end
         end
      end
   end
endmodule : xldc_core

`default_nettype wire

// ==== core/xldc_pkg.sv ====
package xldc_pkg;
   // ------------------------------------------------------------
   // lane geometry and rates
   // ------------------------------------------------------------
   localparam int LANES = 4;
   localparam int WORD_W = 10;
   localparam int BYTE_W = 8;
   localparam int BIT_RATIO = 10;
   localparam logic [3:0] TICK_LAST = 4'(BIT_RATIO - 1);
   localparam logic [3:0] BIT_LAST = 4'(WORD_W - 1);

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_GLOBAL = 8'h10;
   localparam logic [7:0] IDX_LANE_A = 8'h11;
   localparam logic [7:0] IDX_LANE_D = 8'h14;
   localparam logic [7:0] IDX_STATUS = 8'h16;

   // global register fields
   localparam int GL_MODE_LSB = 0;
   localparam int GL_MODE_OVR = 3;
   localparam int GL_IND_MODE = 8;
   localparam int GL_FLAG_SEL_LSB = 9;
   localparam int GL_COMP_EN = 11;
   localparam int GLOBAL_W = 12;
   // lane register fields (bit 2 also exists in the global one)
   localparam int LN_ENC = 0;
   localparam int LN_DEC = 1;
   localparam int LN_SELFTEST = 2;
   localparam int LN_PRE_LSB = 4;
   localparam int LANE_W = 6;
   // status register fields
   localparam int ST_PASS_LSB = 0;
   localparam int ST_MODE_LSB = 4;

   localparam logic [GLOBAL_W-1:0] GLOBAL_RESET = 12'h800;
   localparam logic [LANE_W-1:0] LANE_RESET = 6'h03;
   localparam logic [1:0] FLAG_SEL_PASS = 2'h1;

   // ------------------------------------------------------------
   // characters
   // ------------------------------------------------------------
   localparam logic [7:0] IDLE_BYTE = 8'h07;
   localparam logic [7:0] CHAR_A = 8'h7c;
   localparam logic [7:0] CHAR_K = 8'hbc;
   localparam logic [7:0] CHAR_R = 8'h1c;
   localparam logic [6:0] PRBS_SEED = 7'h7f;
   localparam logic [2:0] PRBS_LOCK = 3'h7;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_DUPLEX = 2'h0,
      MODE_RX_ONLY = 2'h1,
      MODE_REPEAT = 2'h3,
      MODE_TX_ONLY = 2'h2
   } xldc_mode_type;

   typedef enum logic [1:0] {
      PRE_30 = 2'h0,
      PRE_20 = 2'h1,
      PRE_10 = 2'h2,
      PRE_OFF = 2'h3
   } xldc_preemph_type;

   typedef struct packed {
      logic [LANES-1:0][WORD_W-1:0] enc_word;
      logic [LANES-1:0][WORD_W-1:0] raw_word;
   } xldc_tx_in_type;

   typedef struct packed {
      logic [LANES-1:0] data;
      logic [LANES-1:0] oe;
   } xldc_ser_out_type;

   typedef struct packed {
      logic [LANES-1:0][BYTE_W-1:0] data;
      logic [LANES-1:0] ctrl;
   } xldc_dec_in_type;

   typedef struct packed {
      logic [LANES-1:0][BYTE_W-1:0] data;
      logic [LANES-1:0] ctrl;
      logic [LANES-1:0] valid;
      logic oe;
   } xldc_rx_out_type;
endpackage : xldc_pkg

// ==== verif/test_xaui_lane_datapath_control.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module test_xaui_lane_datapath_control;
   import xldc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, tx_pwr, rx_pwr, link_en = 1'b0, flip = 1'b0;
   logic mode_select_lo = 1'b0, mode_select_hi = 1'b0;
   logic selftest_enable_pin = 1'b0, sync_enable_input = 1'b0;
   xldc_tx_in_type tx_in = '0;
   xldc_dec_in_type dec_in = '0;
   xldc_ser_out_type serial_tx;
   xldc_rx_out_type rx_out;
   logic [LANES-1:0][1:0] lane_preemph;
   logic [LANES-1:0] rx_bits, rx_stb, flag_out;
   logic [LANES-1:0][WORD_W-1:0] rx_code;
   int err_count = 0, check_count = 0;
   always #50 pclk = ~pclk;
   xldc_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .mode_select_lo, .mode_select_hi, .selftest_enable_pin,
      .sync_enable_input, .tx_in, .serial_tx, .lane_preemph, .serial_rx_pair(rx_bits),
      .serial_rx_strobe(rx_stb), .rx_code, .rx_code_valid(), .dec_in, .rx_out,
      .lane_a_rx_clock(), .lane_multifunction_out(flag_out), .tx_power_en(tx_pwr),
      .rx_power_en(rx_pwr));
   xldc_remote #(.LAT(3)) u_far (.clk(pclk), .en(link_en), .flip, .tx_bits(serial_tx.data),
      .rx_bits, .rx_stb);
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         err_count++;
         $display("mismatch at %0t: got %h exp %h", $time, g, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, ix, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic grab(output logic [19:0] b);
      for (int i = 0; i < 20; i++) begin
         @(posedge pclk);
         b[i] = serial_tx.data[0];
      end
   endtask : grab
   task automatic wait_valid;
      int n;
      n = 0;
      repeat (2) begin
         @(posedge pclk);
         while (rx_out.valid[0] !== 1'b1 && n < 80) begin
            @(posedge pclk);
            n++;
         end
      end
      chk(32'(rx_out.valid[0]), 32'h1);
   endtask : wait_valid
   task automatic t_regs;
      xldc_preemph_type lv [4];
      lv = '{PRE_30, PRE_20, PRE_10, PRE_OFF};
      apb(1'b0, IDX_GLOBAL, 32'h0);
      chk(rd, 32'h800);
      apb(1'b0, 8'h15, 32'h0);
      chk(32'(er), 32'h1);
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, IDX_LANE_D, 32'(p * 16 + 3));
         cyc(2);
         chk(32'(lane_preemph[3]), 32'(lv[p]));
      end
      $display("regs end");
   endtask : t_regs
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         mode_select_lo <= m[0];
         mode_select_hi <= m[1];
         cyc(4);
         apb(1'b0, IDX_STATUS, 32'h0);
         chk(32'(rd[5:4]), 32'(m));
         chk(32'(serial_tx.oe), (m == 1) ? 32'h0 : 32'hf);
         chk(32'(rx_out.oe), 32'(m != 2));
         chk(32'({tx_pwr, rx_pwr}), 32'({m != 1, m != 2}));
      end
      mode_select_lo <= 1'b0;
      mode_select_hi <= 1'b0;
      cyc(4);
      $display("modes end");
   endtask : t_modes
   task automatic t_tx;
      logic [19:0] bb;
      logic hit;
      tx_in.enc_word <= {LANES{10'h00b}};
      tx_in.raw_word <= {LANES{10'h3ff}};
      cyc(25);
      grab(bb);
      hit = 1'b0;
      for (int k = 0; k < 10; k++) begin
         hit |= (bb[k +: 10] == 10'h00b);
      end
      chk(32'(hit), 32'h1);
      apb(1'b1, IDX_LANE_A, 32'h2);
      cyc(25);
      grab(bb);
      chk(32'(bb[9:0]), 32'h3ff);
      apb(1'b1, IDX_LANE_A, 32'h3);
      $display("tx end");
   endtask : t_tx
   task automatic t_rx;
      logic [8:0] ch [4];
      logic hit;
      ch = '{{1'b1, CHAR_A}, {1'b1, CHAR_K}, {1'b1, CHAR_R}, 9'h05a};
      apb(1'b1, IDX_GLOBAL, 32'h900);
      link_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         dec_in.ctrl <= {LANES{ch[i][8]}};
         dec_in.data <= {LANES{ch[i][7:0]}};
         wait_valid();
         chk(32'(rx_out.data), ch[i][8] ? {4{IDLE_BYTE}} : {4{8'h5a}});
         chk(32'(rx_out.ctrl), ch[i][8] ? 32'hf : 32'h0);
      end
      // looped-back encoder word arrives at an unknown bit phase: any rotation
      hit = 1'b0;
      for (int k = 0; k < 10; k++) begin
         hit |= (({rx_code[0], rx_code[0]} >> k) & 20'h3ff) == 20'h00b;
      end
      chk(32'(hit), 32'h1);
      apb(1'b1, IDX_GLOBAL, 32'h800);
      // first columns after the switch may be leftovers or empty-fifo idles
      wait_valid();
      wait_valid();
      chk(32'(rx_out.data), {4{8'h5a}});
      $display("rx end");
   endtask : t_rx
   task automatic t_self;
      apb(1'b1, IDX_GLOBAL, 32'ha00);
      selftest_enable_pin <= 1'b1;
      cyc(80);
      chk(32'(flag_out), 32'hf);
      sync_enable_input <= 1'b1;
      cyc(2);
      flip <= 1'b1;
      cyc(1);
      flip <= 1'b0;
      cyc(30);
      chk(32'(flag_out), 32'h0);
      sync_enable_input <= 1'b0;
      cyc(30);
      chk(32'(flag_out), 32'hf);
      selftest_enable_pin <= 1'b0;
      apb(1'b1, IDX_LANE_A, 32'h7);
      cyc(80);
      chk(32'(flag_out[0]), 32'h1);
      // only lane a runs its checker now, so only lane a may latch an error
      sync_enable_input <= 1'b1;
      cyc(2);
      flip <= 1'b1;
      cyc(1);
      flip <= 1'b0;
      cyc(30);
      chk(32'(flag_out), 32'he);
      sync_enable_input <= 1'b0;
      $display("self end");
   endtask : t_self
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      cyc(12);
      presetn <= 1'b1;
      t_regs();
      t_modes();
      t_tx();
      t_rx();
      t_self();
      close_out();
   end
   initial begin
      cyc(20000);
      err_count++;
      close_out();
   end
endmodule : test_xaui_lane_datapath_control
`default_nettype wire

// ==== verif/xldc_core_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module xldc_core_monitor (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   // terminals and outputs
   input wire logic mode_select_lo,
   input wire logic mode_select_hi,
   input wire logic sync_enable_input,
   input wire xldc_pkg::xldc_ser_out_type serial_tx,
   input wire logic [xldc_pkg::LANES-1:0][1:0] lane_preemph,
   input wire logic [xldc_pkg::LANES-1:0] rx_code_valid,
   input wire xldc_pkg::xldc_rx_out_type rx_out,
   input wire logic lane_a_rx_clock,
   input wire logic [xldc_pkg::LANES-1:0] lane_multifunction_out,
   input wire logic tx_power_en
);
   import xldc_pkg::*;
   logic wr;
   logic [1:0] pins;
   assign wr = psel && penable && pready && pwrite;
   assign pins = {mode_select_hi, mode_select_lo};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_duplex_drive: assert property (
      (pins == 2'h0) [*4] |-> serial_tx.oe == 4'hf && rx_out.oe) else $error("duplex off");
   a_txonly_float: assert property (
      (pins == 2'h2) [*4] |-> !rx_out.oe) else $error("rx bus driven");
   a_rxonly_float: assert property (
      (pins == 2'h1) [*4] |-> serial_tx.oe == 4'h0 && !tx_power_en) else $error("tx driven");
   a_repeat_drive: assert property (
      (pins == 2'h3) [*4] |-> serial_tx.oe == 4'hf) else $error("repeater tx off");
   a_preemph_write: assert property (
      $changed(lane_preemph) |-> $past(wr) || $past(wr, 2)) else $error("preemph moved");
   a_pass_latch: assert property (
      ($fell(lane_multifunction_out[0]) && sync_enable_input) ##1 sync_enable_input [*3]
      |-> !lane_multifunction_out[0]) else $error("pass not latched");
   a_lane_a_gap: assert property (
      lane_a_rx_clock |=> !lane_a_rx_clock [*8]) else $error("column pulse spacing");
   a_word_gap: assert property (
      rx_code_valid[0] |=> !rx_code_valid[0] [*8]) else $error("word pulse spacing");
   c_rx_word: cover property (rx_out.valid[0]);
   c_latch: cover property (sync_enable_input && $fell(lane_multifunction_out[0]));
   c_tx_float: cover property (serial_tx.oe == 4'h0);
endmodule : xldc_core_monitor

bind xldc_core xldc_core_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
   .mode_select_lo, .mode_select_hi, .sync_enable_input, .serial_tx, .lane_preemph,
   .rx_code_valid, .rx_out, .lane_a_rx_clock, .lane_multifunction_out, .tx_power_en);
`default_nettype wire

// ==== verif/xldc_remote.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// far transceiver echoing the lanes
// ----
module xldc_remote #(
   parameter int LAT = 3
) (
   // link
   input wire logic clk,
   input wire logic en,
   input wire logic flip,
   input wire logic [3:0] tx_bits,
   output logic [3:0] rx_bits,
   output logic [3:0] rx_stb
);
   logic [LAT-1:0][3:0] pipe;
   initial rx_bits = 4'h0;
   always @(posedge clk) begin
      pipe <= {pipe[LAT-2:0], tx_bits};
      // off link: line toggles so stale bits never look valid
      rx_bits <= en ? (pipe[LAT-1] ^ {4{flip}}) : ~rx_bits;
      rx_stb <= {4{en}};
   end
endmodule : xldc_remote
`default_nettype wire
